// [hw/mrr_pkg.sv]
// Constants shared by the measurement result register bank
package mrr_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_CELL8 = 10'h04e;
    localparam logic [9:0] IDX_CELL9 = 10'h04f;
    localparam logic [9:0] IDX_CELL10 = 10'h050;
    localparam logic [9:0] IDX_CELL11 = 10'h051;
    localparam logic [9:0] IDX_CELL12 = 10'h052;
    localparam logic [9:0] IDX_CELL13 = 10'h053;
    localparam logic [9:0] IDX_CELL14 = 10'h054;
    localparam logic [9:0] IDX_STACK = 10'h055;
    localparam logic [9:0] IDX_SUM = 10'h056;
    localparam logic [9:0] IDX_DIAG_A = 10'h057;
    localparam logic [9:0] IDX_DIAG_B = 10'h058;
    localparam logic [9:0] IDX_AUX0 = 10'h059;
    localparam logic [9:0] IDX_AUX1 = 10'h05a;
    localparam logic [9:0] IDX_FIRST = IDX_CELL8;
    localparam logic [9:0] IDX_LAST = IDX_AUX1;
    // Control registers
    localparam logic [9:0] IDX_MEAS_EN = 10'h070;
    localparam logic [9:0] IDX_CTRL = 10'h071;
    localparam logic [9:0] IDX_DIAG_CFG = 10'h072;
    localparam logic [9:0] IDX_POLARITY = 10'h073;
    // Storage slots (index minus IDX_FIRST)
    localparam int SLOTS = 13;
    localparam logic [3:0] SLOT_STACK = 4'h7;
    localparam logic [3:0] SLOT_SUM = 4'h8;
    localparam logic [3:0] SLOT_DIAG_A = 4'h9;
    localparam logic [3:0] SLOT_DIAG_B = 4'ha;
    localparam logic [3:0] SLOT_AUX0 = 4'hb;
    localparam logic [3:0] SLOT_AUX1 = 4'hc;
    // Conversion channel codes from the scan engine
    localparam logic [4:0] CH_CURRENT = 5'h00;
    localparam logic [4:0] CH_CELL1 = 5'h01;
    localparam logic [4:0] CH_CELL8 = 5'h08;
    localparam logic [4:0] CH_CELL14 = 5'h0e;
    localparam logic [4:0] CH_STACK = 5'h0f;
    localparam logic [4:0] CH_DIAG_A = 5'h10;
    localparam logic [4:0] CH_DIAG_B = 5'h11;
    localparam logic [4:0] CH_AUX0 = 5'h12;
    localparam logic [4:0] CH_AUX1 = 5'h13;
    // Control register fields
    localparam int CTRL_STACK_EN = 0;
    localparam int CTRL_AUX0_EN = 1;
    localparam int CTRL_AUX1_EN = 2;
    localparam int CTRL_FILT_SEL = 3;
    localparam int CTRL_AUX0_ANALOG = 4;
    localparam int CTRL_AUX1_ANALOG = 5;
    localparam int CTRL_AUX0_ABS = 6;
    localparam int CTRL_AUX1_ABS = 7;
    localparam int DIAG_A_LSB = 0;
    localparam int DIAG_B_LSB = 4;
    // Results sit in bits 15:2
    localparam int RES_LSB = 2;
    localparam logic [13:0] BIPOLAR_ZERO = 14'h2000;
    localparam logic [15:0] SUM_MAX = 16'hffff;
    localparam logic [15:0] RESET_VAL = 16'h0000;
endpackage

// [hw/mrr_result_bank.sv]
// Measurement result register bank with APB slave and enabled-cell sum
// What this block does
// - Cell results held as 14-bit codes in bits 15:2, bits 1:0 zero
// - Cell codes span a 5 V input range
// - Disabled, skipped cell keeps data; readback picks filtered or raw
// - Stack voltage held as 14-bit code in bits 15:2, 65 V span
// - Disabled, skipped stack measurement keeps data; readback per filter select
// - 16-bit sum of only the cells enabled in the latest scan
// - Sum is unipolar with 1.22 mV per bit, 0 to 80 V
// - Stale results of disabled cells stay stored but are not summed
// - Each cell is summed per its own unipolar or bipolar format
// - Current-sense result never enters the sum
// - A negative sum is clipped to zero
// - Diagnostic A result stored as 14-bit code in bits 15:2
// - Diagnostic B result stored as 14-bit code in bits 15:2
// - Auxiliary results are 14-bit codes in bits 15:2, ratiometric or absolute
// - Auxiliary pin not set as analog input reads back zero
// - Configured but disabled, skipped auxiliary keeps previous result
// - Polarity bit clear means unipolar 0..5 V, set means bipolar +-2.5 V
module mrr_result_bank (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scanStart,
    input wire logic scanDone,
    input wire logic convValid,
    input wire logic [4:0] convChannel,
    input wire logic [13:0] convRaw,
    input wire logic [13:0] convFiltered,
    output logic [13:0] cellMeasureEnable,
    output logic stackMeasureEnable,
    output logic [1:0] auxiliaryMeasureEnable,
    output logic [13:0] cellPolarity,
    output logic [2:0] diagnosticSelectorA,
    output logic [2:0] diagnosticSelectorB,
    output logic [1:0] auxiliaryAbsoluteRef
);
    logic [13:0] rawStore_r [mrr_pkg::SLOTS];
    logic [13:0] filtStore_r [mrr_pkg::SLOTS];
    logic [13:0] measEn_r;
    logic [7:0] ctrl_r;
    logic [7:0] diagnostic_config_r;
    logic [13:0] polarity_r;
    logic signed [19:0] sumAcc_r;
    logic [15:0] sumResult_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [9:0] regIdx;
    logic aligned;
    logic accessDone;
    logic [3:0] convSlot;
    logic convStores;
    logic convIsCell;
    logic convCellEnabled;
    logic [31:0] readData;
    logic readHit;

    // Maps a conversion channel to its storage slot
    function automatic logic [3:0] slot_of(input logic [4:0] ch);
        logic [3:0] s;
        s = 4'h0;
        if (ch >= mrr_pkg::CH_CELL8 && ch <= mrr_pkg::CH_CELL14) begin
            s = 4'(ch - mrr_pkg::CH_CELL8);
        end else if (ch == mrr_pkg::CH_STACK) begin
            s = mrr_pkg::SLOT_STACK;
        end else if (ch == mrr_pkg::CH_DIAG_A) begin
            s = mrr_pkg::SLOT_DIAG_A;
        end else if (ch == mrr_pkg::CH_DIAG_B) begin
            s = mrr_pkg::SLOT_DIAG_B;
        end else if (ch == mrr_pkg::CH_AUX0) begin
            s = mrr_pkg::SLOT_AUX0;
        end else if (ch == mrr_pkg::CH_AUX1) begin
            s = mrr_pkg::SLOT_AUX1;
        end
        return s;
    endfunction

    // Converts a 14-bit cell code to sum units; one sum bit is four code steps
    function automatic logic signed [19:0] sum_term(input logic [13:0] code,
                                                     input logic bipolar);
        logic signed [14:0] diff;
        logic signed [19:0] t;
        diff = $signed({1'b0, code}) - $signed({1'b0, mrr_pkg::BIPOLAR_ZERO});
        if (bipolar) begin
            t = {{7{diff[14]}}, diff[14:2]};
        end else begin
            t = {8'h00, code[13:2]};
        end
        return t;
    endfunction

    assign regIdx = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign accessDone = psel && penable && pready_r;
    assign convSlot = slot_of(convChannel);
    assign convIsCell = (convChannel >= mrr_pkg::CH_CELL1) && (convChannel <= mrr_pkg::CH_CELL14);
    assign convCellEnabled = convIsCell && measEn_r[4'(convChannel - mrr_pkg::CH_CELL1)];

    // Only enabled cell, stack and aux channels and both diagnostics overwrite storage; skipped ones keep old data
    always_comb begin
        convStores = 1'b0;
        if (convValid) begin
            if (convChannel >= mrr_pkg::CH_CELL8 && convChannel <= mrr_pkg::CH_CELL14) begin
                convStores = convCellEnabled;
            end else if (convChannel == mrr_pkg::CH_STACK) begin
                convStores = ctrl_r[mrr_pkg::CTRL_STACK_EN];
            end else if (convChannel == mrr_pkg::CH_DIAG_A || convChannel == mrr_pkg::CH_DIAG_B) begin
                convStores = 1'b1;
            end else if (convChannel == mrr_pkg::CH_AUX0) begin
                convStores = ctrl_r[mrr_pkg::CTRL_AUX0_EN];
            end else if (convChannel == mrr_pkg::CH_AUX1) begin
                convStores = ctrl_r[mrr_pkg::CTRL_AUX1_EN];
            end
        end
    end

    // Result storage, written only by the scan engine
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < mrr_pkg::SLOTS; i++) begin
                rawStore_r[i] <= 14'h0000;
                filtStore_r[i] <= 14'h0000;
            end
        end else if (convStores) begin
            rawStore_r[convSlot] <= convRaw;
            // Diagnostics have no filter path, so both copies hold the raw code
            if (convSlot == mrr_pkg::SLOT_DIAG_A || convSlot == mrr_pkg::SLOT_DIAG_B) begin
                filtStore_r[convSlot] <= convRaw;
            end else begin
                filtStore_r[convSlot] <= convFiltered;
            end
        end
    end

    // Sum accumulates per scan; a start in the same cycle as a conversion restarts at it
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sumAcc_r <= 20'sh00000;
        end else if (scanStart) begin
            if (convValid && convCellEnabled) begin
                sumAcc_r <= sum_term(convRaw, polarity_r[4'(convChannel - mrr_pkg::CH_CELL1)]);
            end else begin
                sumAcc_r <= 20'sh00000;
            end
        end else if (convValid && convCellEnabled) begin
            // Current sense and non-cell channels fail convCellEnabled
            sumAcc_r <= sumAcc_r + sum_term(convRaw, polarity_r[4'(convChannel - mrr_pkg::CH_CELL1)]);
        end
    end

    // Published at scan end so a read never sees a partial sum
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sumResult_r <= mrr_pkg::RESET_VAL;
        end else if (scanDone) begin
            if (sumAcc_r < 0) begin
                sumResult_r <= 16'h0000;
            end else if (sumAcc_r > $signed({4'h0, mrr_pkg::SUM_MAX})) begin
                sumResult_r <= mrr_pkg::SUM_MAX;
            end else begin
                sumResult_r <= sumAcc_r[15:0];
            end
        end
    end

    // Control registers, written on the completing access edge
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            measEn_r <= 14'h0000;
            ctrl_r <= 8'h00;
            diagnostic_config_r <= 8'h00;
            polarity_r <= 14'h0000;
        end else if (accessDone && pwrite && aligned) begin
            if (regIdx == mrr_pkg::IDX_MEAS_EN) begin
                measEn_r <= pwdata[13:0];
            end else if (regIdx == mrr_pkg::IDX_CTRL) begin
                ctrl_r <= pwdata[7:0];
            end else if (regIdx == mrr_pkg::IDX_DIAG_CFG) begin
                diagnostic_config_r <= {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
            end else if (regIdx == mrr_pkg::IDX_POLARITY) begin
                polarity_r <= pwdata[13:0];
            end
        end
    end

    // Read decode
    always_comb begin
        logic [3:0] s;
        logic [13:0] code;
        s = 4'(regIdx - mrr_pkg::IDX_FIRST);
        code = 14'h0000;
        readData = 32'h00000000;
        readHit = 1'b1;
        if (!aligned) begin
            readHit = 1'b0;
        end else if (regIdx == mrr_pkg::IDX_SUM) begin
            readData = {16'h0000, sumResult_r};
        end else if (regIdx >= mrr_pkg::IDX_FIRST && regIdx <= mrr_pkg::IDX_LAST) begin
            code = ctrl_r[mrr_pkg::CTRL_FILT_SEL] ? filtStore_r[s] : rawStore_r[s];
            if (s == mrr_pkg::SLOT_AUX0 && !ctrl_r[mrr_pkg::CTRL_AUX0_ANALOG]) begin
                code = 14'h0000;
            end else if (s == mrr_pkg::SLOT_AUX1 && !ctrl_r[mrr_pkg::CTRL_AUX1_ANALOG]) begin
                code = 14'h0000;
            end
            readData = {16'h0000, code, 2'b00};
        end else if (regIdx == mrr_pkg::IDX_MEAS_EN) begin
            readData = {18'h00000, measEn_r};
        end else if (regIdx == mrr_pkg::IDX_CTRL) begin
            readData = {24'h000000, ctrl_r};
        end else if (regIdx == mrr_pkg::IDX_DIAG_CFG) begin
            readData = {24'h000000, diagnostic_config_r};
        end else if (regIdx == mrr_pkg::IDX_POLARITY) begin
            readData = {18'h00000, polarity_r};
        end else begin
            readHit = 1'b0;
        end
    end

    // One wait-free answer: data and ready are set up during the setup phase
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else if (psel && !penable) begin
            pready_r <= 1'b1;
            pslverr_r <= !readHit;
            // Writes to result registers are dropped silently
            prdata_r <= pwrite ? 32'h00000000 : readData;
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign cellMeasureEnable = measEn_r;
    assign stackMeasureEnable = ctrl_r[mrr_pkg::CTRL_STACK_EN];
    assign auxiliaryMeasureEnable = {ctrl_r[mrr_pkg::CTRL_AUX1_EN], ctrl_r[mrr_pkg::CTRL_AUX0_EN]};
    assign cellPolarity = polarity_r;
    assign diagnosticSelectorA = diagnostic_config_r[mrr_pkg::DIAG_A_LSB +: 3];
    assign diagnosticSelectorB = diagnostic_config_r[mrr_pkg::DIAG_B_LSB +: 3];
    // Scale choice for the aux converter reference; stored codes are unaffected
    assign auxiliaryAbsoluteRef = {ctrl_r[mrr_pkg::CTRL_AUX1_ABS], ctrl_r[mrr_pkg::CTRL_AUX0_ABS]};
endmodule // mrr_result_bank

// [sim/mrr_result_bank_checker.sv]
// Port checker for the measurement result register bank
module mrr_result_bank_checker (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [13:0] cellMeasureEnable,
    input wire logic stackMeasureEnable,
    input wire logic [13:0] cellPolarity,
    input wire logic [2:0] diagnosticSelectorA,
    input wire logic [2:0] diagnosticSelectorB
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    wire logic [9:0] idx = paddr[11:2];
    wire logic inRes = idx >= mrr_pkg::IDX_FIRST && idx <= mrr_pkg::IDX_LAST;
    wire logic wrDone = psel && penable && pready && pwrite;
    // Written data held one cycle so control outputs can be tied to it
    logic [31:0] lastWr;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lastWr <= 32'h0;
        end else begin
            lastWr <= pwdata;
        end
    end
    setup_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("no single-cycle answer after setup");
    ro_write_ok_a: assert property (wrDone && inRes |-> !pslverr)
        else $error("write to result register flagged");
    err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response carries data");
    res_layout_a: assert property (pready && !pwrite && inRes && idx != mrr_pkg::IDX_SUM
        |-> prdata[1:0] == 2'h0 && prdata[31:16] == 16'h0) else $error("result layout wrong");
    sum_width_a: assert property (pready && !pwrite && idx == mrr_pkg::IDX_SUM
        |-> prdata[31:16] == 16'h0) else $error("sum wider than 16 bits");
    cell_enable_a: assert property (wrDone && idx == mrr_pkg::IDX_MEAS_EN
        |=> cellMeasureEnable == lastWr[13:0]) else $error("cell enables not updated");
    polarity_set_a: assert property (wrDone && idx == mrr_pkg::IDX_POLARITY
        |=> cellPolarity == lastWr[13:0]) else $error("polarity not updated");
    diag_select_a: assert property (wrDone && idx == mrr_pkg::IDX_DIAG_CFG
        |=> diagnosticSelectorA == lastWr[2:0] && diagnosticSelectorB == lastWr[6:4])
        else $error("diagnostic selectors not updated");
    stack_enable_a: assert property (wrDone && idx == mrr_pkg::IDX_CTRL
        |=> stackMeasureEnable == lastWr[0]) else $error("stack enable not updated");
endmodule // mrr_result_bank_checker

bind mrr_result_bank mrr_result_bank_checker u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cellMeasureEnable(cellMeasureEnable),
    .stackMeasureEnable(stackMeasureEnable), .cellPolarity(cellPolarity),
    .diagnosticSelectorA(diagnosticSelectorA), .diagnosticSelectorB(diagnosticSelectorB));

// [sim/mrr_result_bank_test.sv]
// Self-checking bench for the measurement result register bank
module mrr_result_bank_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdData;
    logic pready, pslverr, errSeen, scanStart = 1'h0, scanDone = 1'h0, convValid = 1'h0;
    logic [4:0] convChannel = 5'h00;
    logic [13:0] convRaw = 14'h0, convFiltered = 14'h0, cellMeasureEnable, cellPolarity;
    logic stackMeasureEnable;
    logic [1:0] auxiliaryMeasureEnable, auxiliaryAbsoluteRef;
    logic [2:0] diagnosticSelectorA, diagnosticSelectorB;
    logic [4:0] chTab [10] = '{5'h01, 5'h08, 5'h09, 5'h0a, 5'h00, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13};
    logic [13:0] rawTab [10] = '{14'h1000, 14'h0800, 14'h2400, 14'h0040, 14'h3fff, 14'h1234,
        14'h0111, 14'h0222, 14'h0333, 14'h0444};
    logic [9:0] idxTab [9] = '{10'h04e, 10'h04f, 10'h050, 10'h055, 10'h056, 10'h057, 10'h058,
        10'h059, 10'h05a};
    logic [15:0] expTab [9] = '{16'h2000, 16'h9000, 16'h0100, 16'h48d0, 16'h0710, 16'h0444,
        16'h0888, 16'h0ccc, 16'h0000};
    int err_total = 0, checks = 0;
    always #4 sys_clk = ~sys_clk;
    mrr_result_bank uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scanStart(scanStart), .scanDone(scanDone), .convValid(convValid),
        .convChannel(convChannel), .convRaw(convRaw), .convFiltered(convFiltered),
        .cellMeasureEnable(cellMeasureEnable), .stackMeasureEnable(stackMeasureEnable),
        .auxiliaryMeasureEnable(auxiliaryMeasureEnable), .cellPolarity(cellPolarity),
        .diagnosticSelectorA(diagnosticSelectorA), .diagnosticSelectorB(diagnosticSelectorB),
        .auxiliaryAbsoluteRef(auxiliaryAbsoluteRef));
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Request held until pready is sampled high; released only after that edge
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        int n = 0;
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'h1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        // A slave that never answers counts as a mismatch
        if (pready !== 1'h1) begin
            err_total++;
            $display("BAD pready expected 1 seen %b", pready);
        end
        rdData = prdata;
        errSeen = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rd(input logic [9:0] idx, input logic [15:0] exp);
        apb(1'h0, idx, 32'h0);
        cmp($sformatf("reg %h", idx), {16'h0, exp}, rdData);
        cmp("pslverr", 32'h0, {31'h0, errSeen});
    endtask
    // s: bit 0 scan start, bit 1 conversion, bit 2 scan done
    task automatic ev(input logic [2:0] s, input logic [4:0] ch, input logic [13:0] raw);
        @(posedge sys_clk);
        scanStart <= s[0];
        convValid <= s[1];
        scanDone <= s[2];
        convChannel <= ch;
        convRaw <= raw;
        convFiltered <= raw + 14'h0004;
        @(posedge sys_clk);
        scanStart <= 1'h0;
        convValid <= 1'h0;
        scanDone <= 1'h0;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        wrap_up();
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'h0;
        for (int i = 0; i < 13; i++) rd(mrr_pkg::IDX_FIRST + 10'(i), 16'h0000);
        $display("test reset values done");
        apb(1'h1, mrr_pkg::IDX_CTRL, 32'h0000_0053);
        apb(1'h1, mrr_pkg::IDX_MEAS_EN, 32'h0000_0381);
        apb(1'h1, mrr_pkg::IDX_POLARITY, 32'h0000_0100);
        apb(1'h1, mrr_pkg::IDX_DIAG_CFG, 32'h0000_0053);
        @(negedge sys_clk);
        cmp("enables", {4'h0, 14'h0381, 14'h0100}, {4'h0, cellMeasureEnable, cellPolarity});
        cmp("selects", 32'h0000_03b5, {21'h0, diagnosticSelectorA, diagnosticSelectorB,
            stackMeasureEnable, auxiliaryMeasureEnable, auxiliaryAbsoluteRef});
        ev(3'h1, 5'h00, 14'h0000);
        for (int i = 0; i < 10; i++) ev(3'h2, chTab[i], rawTab[i]);
        ev(3'h4, 5'h00, 14'h0000);
        for (int i = 0; i < 9; i++) rd(idxTab[i], expTab[i]);
        $display("test mixed scan done");
        apb(1'h1, mrr_pkg::IDX_CTRL, 32'h0000_005b);
        rd(mrr_pkg::IDX_CELL8, 16'h2010);
        rd(mrr_pkg::IDX_DIAG_A, 16'h0444);
        apb(1'h1, mrr_pkg::IDX_CELL8, 32'h0000_ffff);
        cmp("ro write pslverr", 32'h0, {31'h0, errSeen});
        apb(1'h0, 10'h3ff, 32'h0);
        cmp("unmapped", 32'h1, {rdData[30:0], errSeen});
        apb(1'h1, mrr_pkg::IDX_CTRL, 32'h0000_0052);
        apb(1'h1, mrr_pkg::IDX_MEAS_EN, 32'h0000_0100);
        ev(3'h1, 5'h08, 14'h3000);
        ev(3'h2, 5'h09, 14'h1000);
        ev(3'h2, 5'h0f, 14'h0fff);
        ev(3'h4, 5'h00, 14'h0000);
        rd(mrr_pkg::IDX_CELL8, 16'h2000);
        rd(mrr_pkg::IDX_CELL9, 16'h4000);
        rd(mrr_pkg::IDX_STACK, 16'h48d0);
        rd(mrr_pkg::IDX_SUM, 16'h0000);
        $display("test disabled and clipped done");
        apb(1'h1, mrr_pkg::IDX_CTRL, 32'h0000_0040);
        rd(mrr_pkg::IDX_AUX0, 16'h0000);
        apb(1'h1, mrr_pkg::IDX_CTRL, 32'h0000_0010);
        ev(3'h2, 5'h12, 14'h0001);
        rd(mrr_pkg::IDX_AUX0, 16'h0ccc);
        $display("test auxiliary done");
        wrap_up();
    end
endmodule // mrr_result_bank_test
